/* pdm_top.sv */
// Functional notes
// R1 - standby select picks sleep or software standby
// R2 - standby select stays set after interrupt exit
// R3 - settle wait field maps to state counts
// R4 - hold cpu and peripherals during settle wait
// R5 - software sets crystal wait of 7 ms
// R6 - software sets external clock wait 100 us
// R7 - bus drive 0 floats bus in standby
// R8 - bus drive 1 holds address, strobes high
// R9 - high standby register loads 78 on reset
// R10 - low standby register loads 00 on reset
// R11 - clock output stop gates system clock pin
// R12 - high bits 6..3 read one, bit 2 stored
// R13 - high bits 1,0 stop serial channels
// R14 - low bit 4 stops 16-bit timer
// R15 - low bits 3,2 stop 8-bit timer pairs
// R16 - low bit 0 stops the converter
// R17 - low reserved bits are plain storage
// R18 - sleep halts cpu only, peripherals keep running
// R19 - enabled interrupt ends sleep, disabled does not
// R20 - masked non-nmi interrupt keeps sleeping
// R21 - init pin low in sleep resets device
// R22 - standby pin low enters hardware standby
// R23 - cleared standby bit restarts peripheral from reset
module pdm_top (
  input wire logic CLK, // 250 MHz system clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic CE, // clock enable, freezes state when low
  input wire logic [19:0] REG_ADDR, // register address
  input wire logic [7:0] REG_WDATA, // register write data
  input wire logic REG_WR, // write strobe
  input wire logic REG_RD, // read strobe
  output logic [7:0] REG_RDATA, // read data, cycle after strobe
  input wire logic CHIP_INIT_PIN_N, // chip reset pin, active low
  input wire logic HW_STANDBY_PIN_N, // hardware standby pin, active low
  input wire logic HALT_EXEC, // cpu executes halt instruction, pulse
  input wire logic NMI_REQ, // non-maskable interrupt request
  input wire logic [2:0] EXT_IRQ_REQ, // external interrupt lines
  input wire logic [2:0] EXT_IRQ_EN, // external interrupt enables
  input wire logic PERIPH_IRQ_REQ, // peripheral interrupt enabled in peripheral
  input wire logic IRQ_ACCEPT, // interrupt passes priority and cpu mask
  input wire logic [23:0] CPU_ADDR, // cpu address bus
  input wire logic [7:0] CPU_CS_N, // cpu chip selects
  input wire logic [3:0] CPU_STROBE_N, // address, read, high, low write strobes
  input wire logic SYS_CLK_IN, // system clock level for output pin
  output logic CPU_HALT, // cpu halted, registers held
  output logic INTR_EXCEPTION, // start interrupt exception handling, pulse
  output logic DEVICE_RESET, // device held in reset state
  output logic HW_STANDBY, // device in hardware standby
  output logic OSC_STOP, // oscillator halted
  output logic [23:0] ADDR_OUT, // address bus output
  output logic ADDR_OE, // address bus output enable
  output logic [7:0] CHIP_SELECT_N, // chip select outputs
  output logic ADDRESS_STROBE_N, // address strobe output
  output logic READ_STROBE_N, // read strobe output
  output logic HIGH_WRITE_STROBE_N, // high write strobe output
  output logic LOW_WRITE_STROBE_N, // low write strobe output
  output logic CTRL_OE, // bus control output enable
  output logic SYS_CLK_OUT, // system clock output pin
  output logic SYS_CLK_OE, // system clock output enable
  output logic [5:0] MOD_STOP, // serial0, serial1, t16, t8_01, t8_23, adc stop
  output logic [5:0] MOD_RESET // per-module reset request
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] sys_pwr_ctrl_ff;
  logic [7:0] mod_hw_standby_pin_n_hi_ff;
  logic [7:0] mod_hw_standby_pin_n_lo_ff;
  logic [7:0] rdata_ff;
  pdm_pkg::pdm_state_t state_ff;
  pdm_pkg::pdm_state_t nxt_state;
  logic [18:0] settle_cnt_ff;
  logic [18:0] nxt_settle_cnt;
  logic [18:0] settle_len;
  logic [23:0] addr_hold_ff;
  logic [7:0] cs_hold_ff;
  logic [3:0] strobe_hold_ff;
  logic clk_out_ff;
  logic intr_ff;

  logic wake_sleep;
  logic wake_hw_standby_pin_n;
  logic in_hw_standby_pin_n;
  logic hw_init;
  logic [5:0] mod_bits;

  assign hw_init = !CHIP_INIT_PIN_N || !HW_STANDBY_PIN_N;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // reset pin and hardware standby both initialise the registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sys_pwr_ctrl_ff <= pdm_pkg::SYS_PWR_CTRL_RST;
    end else if (CE) begin
      if (hw_init) begin
        sys_pwr_ctrl_ff <= pdm_pkg::SYS_PWR_CTRL_RST;
      end else if (REG_WR && REG_ADDR == pdm_pkg::SYS_PWR_CTRL_OFS) begin
        sys_pwr_ctrl_ff <= REG_WDATA; // R2
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mod_hw_standby_pin_n_hi_ff <= pdm_pkg::MOD_HW_STANDBY_PIN_N_HI_RST; // R9
    end else if (CE) begin
      if (hw_init) begin
        mod_hw_standby_pin_n_hi_ff <= pdm_pkg::MOD_HW_STANDBY_PIN_N_HI_RST; // R9
      end else if (REG_WR && REG_ADDR == pdm_pkg::MOD_HW_STANDBY_PIN_N_HI_OFS) begin
        mod_hw_standby_pin_n_hi_ff <= REG_WDATA | pdm_pkg::MOD_HW_STANDBY_PIN_N_HI_FIXED_ONES; // R12
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mod_hw_standby_pin_n_lo_ff <= pdm_pkg::MOD_HW_STANDBY_PIN_N_LO_RST; // R10
    end else if (CE) begin
      if (hw_init) begin
        mod_hw_standby_pin_n_lo_ff <= pdm_pkg::MOD_HW_STANDBY_PIN_N_LO_RST; // R10
      end else if (REG_WR && REG_ADDR == pdm_pkg::MOD_HW_STANDBY_PIN_N_LO_OFS) begin
        mod_hw_standby_pin_n_lo_ff <= REG_WDATA; // R17
      end
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_ff <= 8'h00;
    end else if (CE) begin
      if (!REG_RD) begin
        rdata_ff <= 8'h00;
      end else if (REG_ADDR == pdm_pkg::SYS_PWR_CTRL_OFS) begin
        rdata_ff <= sys_pwr_ctrl_ff;
      end else if (REG_ADDR == pdm_pkg::MOD_HW_STANDBY_PIN_N_HI_OFS) begin
        rdata_ff <= mod_hw_standby_pin_n_hi_ff | pdm_pkg::MOD_HW_STANDBY_PIN_N_HI_FIXED_ONES; // R12
      end else if (REG_ADDR == pdm_pkg::MOD_HW_STANDBY_PIN_N_LO_OFS) begin
        rdata_ff <= mod_hw_standby_pin_n_lo_ff;
      end else if (REG_ADDR == pdm_pkg::PWR_STATUS_OFS) begin
        rdata_ff <= {5'h00, state_ff};
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign REG_RDATA = rdata_ff;

  // ------------------------------------------------------------
  // settling wait
  // ------------------------------------------------------------
  always_comb begin
    case (sys_pwr_ctrl_ff[pdm_pkg::SETTLE_WAIT_LSB +: 3]) // R3
      3'h0: settle_len = pdm_pkg::SETTLE_WAIT_0;
      3'h1: settle_len = pdm_pkg::SETTLE_WAIT_1;
      3'h2: settle_len = pdm_pkg::SETTLE_WAIT_2;
      3'h3: settle_len = pdm_pkg::SETTLE_WAIT_3;
      3'h4: settle_len = pdm_pkg::SETTLE_WAIT_4;
      3'h5: settle_len = pdm_pkg::SETTLE_WAIT_5;
      3'h6: settle_len = pdm_pkg::SETTLE_WAIT_6;
      // illegal code: take the longest wait as the safe choice
      default: settle_len = pdm_pkg::SETTLE_WAIT_5;
    endcase
  end

  // ------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------
  // peripheral wake needs the source enabled in the peripheral and unmasked
  assign wake_sleep = NMI_REQ || (IRQ_ACCEPT && (PERIPH_IRQ_REQ || |(EXT_IRQ_REQ & EXT_IRQ_EN))); // R19 R20
  assign wake_hw_standby_pin_n = NMI_REQ || (IRQ_ACCEPT && |(EXT_IRQ_REQ & EXT_IRQ_EN));

  always_comb begin
    nxt_state = state_ff;
    nxt_settle_cnt = settle_cnt_ff;
    case (state_ff)
      pdm_pkg::PDM_RUN: begin
        if (HALT_EXEC) begin
          if (sys_pwr_ctrl_ff[pdm_pkg::STANDBY_SELECT_BIT]) begin
            nxt_state = pdm_pkg::PDM_SW_HW_STANDBY_PIN_N; // R1
          end else begin
            nxt_state = pdm_pkg::PDM_SLEEP; // R1
          end
        end
      end
      pdm_pkg::PDM_SLEEP: begin
        if (wake_sleep) begin
          nxt_state = pdm_pkg::PDM_RUN; // R19
        end
      end
      pdm_pkg::PDM_SW_HW_STANDBY_PIN_N: begin
        if (wake_hw_standby_pin_n) begin
          nxt_state = pdm_pkg::PDM_SETTLE;
          nxt_settle_cnt = settle_len - 19'h00001;
        end
      end
      pdm_pkg::PDM_SETTLE: begin
        if (settle_cnt_ff == 19'h00000) begin
          nxt_state = pdm_pkg::PDM_RUN; // R4
        end else begin
          nxt_settle_cnt = settle_cnt_ff - 19'h00001; // R4
        end
      end
      pdm_pkg::PDM_HW_HW_STANDBY_PIN_N: begin
        nxt_state = pdm_pkg::PDM_HW_HW_STANDBY_PIN_N;
      end
      default: nxt_state = pdm_pkg::PDM_RUN;
    endcase
    if (!HW_STANDBY_PIN_N) begin
      nxt_state = pdm_pkg::PDM_HW_HW_STANDBY_PIN_N; // R22
    end else if (!CHIP_INIT_PIN_N) begin
      nxt_state = pdm_pkg::PDM_RUN; // R21
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_ff <= pdm_pkg::PDM_RUN;
      settle_cnt_ff <= 19'h00000;
    end else if (CE) begin
      state_ff <= nxt_state;
      settle_cnt_ff <= nxt_settle_cnt;
    end
  end

  // wake pulse into exception handling, after settling if from standby
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      intr_ff <= 1'b0;
    end else if (CE) begin
      intr_ff <= (state_ff == pdm_pkg::PDM_SLEEP && nxt_state == pdm_pkg::PDM_RUN && !hw_init)
        || (state_ff == pdm_pkg::PDM_SETTLE && nxt_state == pdm_pkg::PDM_RUN && !hw_init);
    end
  end

  assign in_hw_standby_pin_n = (state_ff == pdm_pkg::PDM_SW_HW_STANDBY_PIN_N) || (state_ff == pdm_pkg::PDM_SETTLE);
  assign CPU_HALT = state_ff != pdm_pkg::PDM_RUN; // R18 R4
  assign INTR_EXCEPTION = intr_ff;
  assign DEVICE_RESET = !CHIP_INIT_PIN_N; // R21
  assign HW_STANDBY = state_ff == pdm_pkg::PDM_HW_HW_STANDBY_PIN_N; // R22
  assign OSC_STOP = (state_ff == pdm_pkg::PDM_SW_HW_STANDBY_PIN_N) || HW_STANDBY;

  // ------------------------------------------------------------
  // bus pins
  // ------------------------------------------------------------
  // last bus state captured while running, replayed in standby
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      addr_hold_ff <= 24'h000000;
      cs_hold_ff <= 8'hFF;
      strobe_hold_ff <= 4'hF;
    end else if (CE) begin
      if (!in_hw_standby_pin_n) begin
        addr_hold_ff <= CPU_ADDR;
        cs_hold_ff <= CPU_CS_N;
        strobe_hold_ff <= CPU_STROBE_N;
      end
    end
  end

  always_comb begin
    ADDR_OUT = addr_hold_ff;
    CHIP_SELECT_N = cs_hold_ff;
    {ADDRESS_STROBE_N, READ_STROBE_N, HIGH_WRITE_STROBE_N, LOW_WRITE_STROBE_N} = strobe_hold_ff;
    ADDR_OE = !HW_STANDBY;
    CTRL_OE = !HW_STANDBY;
    if (in_hw_standby_pin_n) begin
      if (sys_pwr_ctrl_ff[pdm_pkg::STANDBY_BUS_DRIVE_BIT]) begin
        CHIP_SELECT_N = 8'hFF; // R8
        {ADDRESS_STROBE_N, READ_STROBE_N, HIGH_WRITE_STROBE_N, LOW_WRITE_STROBE_N} = 4'hF; // R8
      end else begin
        ADDR_OE = 1'b0; // R7
        CTRL_OE = 1'b0; // R7
      end
    end
  end

  // ------------------------------------------------------------
  // system clock output
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      clk_out_ff <= 1'b0;
    end else if (CE) begin
      clk_out_ff <= SYS_CLK_IN & ~mod_hw_standby_pin_n_hi_ff[pdm_pkg::CLOCK_OUTPUT_STOP_BIT]; // R11
    end
  end

  assign SYS_CLK_OUT = clk_out_ff;
  assign SYS_CLK_OE = !mod_hw_standby_pin_n_hi_ff[pdm_pkg::CLOCK_OUTPUT_STOP_BIT] && !HW_STANDBY; // R11

  // ------------------------------------------------------------
  // module standby gates
  // ------------------------------------------------------------
  assign mod_bits = {
    mod_hw_standby_pin_n_lo_ff[pdm_pkg::ADC_STANDBY_BIT], // R16
    mod_hw_standby_pin_n_lo_ff[pdm_pkg::TIMER8_CH23_STANDBY_BIT], // R15
    mod_hw_standby_pin_n_lo_ff[pdm_pkg::TIMER8_CH01_STANDBY_BIT], // R15
    mod_hw_standby_pin_n_lo_ff[pdm_pkg::TIMER16_STANDBY_BIT], // R14
    mod_hw_standby_pin_n_hi_ff[pdm_pkg::SERIAL1_STANDBY_BIT], // R13
    mod_hw_standby_pin_n_hi_ff[pdm_pkg::SERIAL0_STANDBY_BIT] // R13
  };

  genvar gi;
  generate
    for (gi = 0; gi < pdm_pkg::NUM_MODULES; gi++) begin : g_gate
      pdm_hw_standby_pin_n_if gif ();
      assign gif.hw_standby_pin_n_req = mod_bits[gi];
      // software and hardware standby halt and reset every module
      assign gif.mod_reset = in_hw_standby_pin_n || HW_STANDBY;
      pdm_module_gate u_gate (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .port_if(gif),
        .stop_o(MOD_STOP[gi]),
        .reset_o(MOD_RESET[gi])
      );
    end
  endgenerate

endmodule : pdm_top

/* pdm_pkg.sv */
package pdm_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [19:0] SYS_PWR_CTRL_OFS = 20'hEE012;
  localparam logic [19:0] MOD_HW_STANDBY_PIN_N_HI_OFS = 20'hEE01C;
  localparam logic [19:0] MOD_HW_STANDBY_PIN_N_LO_OFS = 20'hEE01D;
  localparam logic [19:0] PWR_STATUS_OFS = 20'hEE01E;

  localparam logic [7:0] SYS_PWR_CTRL_RST = 8'h09;
  localparam logic [7:0] MOD_HW_STANDBY_PIN_N_HI_RST = 8'h78;
  localparam logic [7:0] MOD_HW_STANDBY_PIN_N_LO_RST = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int SETTLE_WAIT_LSB = 4;
  localparam int STANDBY_BUS_DRIVE_BIT = 1;
  localparam int CLOCK_OUTPUT_STOP_BIT = 7;
  localparam logic [7:0] MOD_HW_STANDBY_PIN_N_HI_FIXED_ONES = 8'h78;
  localparam int SERIAL1_STANDBY_BIT = 1;
  localparam int SERIAL0_STANDBY_BIT = 0;
  localparam int TIMER16_STANDBY_BIT = 4;
  localparam int TIMER8_CH01_STANDBY_BIT = 3;
  localparam int TIMER8_CH23_STANDBY_BIT = 2;
  localparam int ADC_STANDBY_BIT = 0;

  // ------------------------------------------------------------
  // settling wait counts in states
  // ------------------------------------------------------------
  localparam logic [18:0] SETTLE_WAIT_0 = 19'h02000;
  localparam logic [18:0] SETTLE_WAIT_1 = 19'h04000;
  localparam logic [18:0] SETTLE_WAIT_2 = 19'h08000;
  localparam logic [18:0] SETTLE_WAIT_3 = 19'h10000;
  localparam logic [18:0] SETTLE_WAIT_4 = 19'h20000;
  localparam logic [18:0] SETTLE_WAIT_5 = 19'h40000;
  localparam logic [18:0] SETTLE_WAIT_6 = 19'h00400;

  localparam int NUM_MODULES = 6;

  typedef enum logic [2:0] {
    PDM_RUN = 3'b000,
    PDM_SLEEP = 3'b001,
    PDM_SW_HW_STANDBY_PIN_N = 3'b010,
    PDM_SETTLE = 3'b011,
    PDM_HW_HW_STANDBY_PIN_N = 3'b100
  } pdm_state_t;

endpackage : pdm_pkg

/* pdm_hw_standby_pin_n_if.sv */
interface pdm_hw_standby_pin_n_if;
  logic hw_standby_pin_n_req;
  logic mod_reset;
  logic mod_run;

  modport ctrl (output hw_standby_pin_n_req, output mod_reset, input mod_run);
  modport gate (input hw_standby_pin_n_req, input mod_reset, output mod_run);
endinterface : pdm_hw_standby_pin_n_if

/* pdm_module_gate.sv */
module pdm_module_gate (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset
  input wire logic ce, // clock enable
  pdm_hw_standby_pin_n_if.gate port_if, // standby control
  output logic stop_o, // peripheral clock stop
  output logic reset_o // peripheral reset request
);

  logic stop_ff;
  logic held_ff;

  // restart comes from reset, never from the frozen state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stop_ff <= 1'b0;
      held_ff <= 1'b0;
    end else if (ce) begin
      stop_ff <= port_if.hw_standby_pin_n_req | port_if.mod_reset;
      held_ff <= port_if.hw_standby_pin_n_req | port_if.mod_reset | (held_ff & stop_ff);
    end
  end

  assign stop_o = stop_ff;
  assign reset_o = held_ff; // R23
  assign port_if.mod_run = ~stop_ff;

endmodule : pdm_module_gate

/* pdm_top_chk.sv */
module pdm_top_chk (
  input wire logic CLK, // system clock
  input wire logic RST_N, // sync reset
  input wire logic CHIP_INIT_PIN_N, // init pin
  input wire logic HW_STANDBY_PIN_N, // standby pin
  input wire logic HALT_EXEC, // halt pulse
  input wire logic NMI_REQ, // nmi
  input wire logic IRQ_ACCEPT, // unmasked irq
  input wire logic CPU_HALT, // cpu halted
  input wire logic INTR_EXCEPTION, // wake pulse
  input wire logic HW_STANDBY, // hw standby
  input wire logic OSC_STOP, // osc stopped
  input wire logic [23:0] ADDR_OUT, // address out
  input wire logic ADDR_OE, // address enable
  input wire logic [7:0] CHIP_SELECT_N, // selects
  input wire logic CTRL_OE, // control enable
  input wire logic [5:0] MOD_STOP, // module stops
  input wire logic [5:0] MOD_RESET // module resets
);
  // ----------------------------------------
  // power state checks
  // ----------------------------------------
  wire logic pins_ok = CHIP_INIT_PIN_N && HW_STANDBY_PIN_N;
  logic from_hw_standby_pin_n_ff;
  wire logic in_sleep = CPU_HALT && !OSC_STOP && !from_hw_standby_pin_n_ff && pins_ok;

  // settle follows an interrupt exit from software standby: remember it until the cpu runs
  always_ff @(posedge CLK) begin
    if (!RST_N || !CPU_HALT) begin
      from_hw_standby_pin_n_ff <= 1'b0;
    end else if (OSC_STOP) begin
      from_hw_standby_pin_n_ff <= 1'b1;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_HALT_ENTRY: assert property (HALT_EXEC && !CPU_HALT && pins_ok |=> CPU_HALT)
    else $error("halt did not stop cpu");
  AST_WAKE: assert property (in_sleep && NMI_REQ |=> !CPU_HALT && INTR_EXCEPTION)
    else $error("nmi did not wake from sleep");
  AST_MASKED: assert property (in_sleep && !NMI_REQ && !IRQ_ACCEPT |=> CPU_HALT)
    else $error("masked irq woke the cpu");
  AST_INIT_PIN: assert property (!CHIP_INIT_PIN_N && HW_STANDBY_PIN_N |=> !CPU_HALT)
    else $error("init pin did not restore run");
  AST_HW_PIN: assert property (!HW_STANDBY_PIN_N |=> HW_STANDBY && OSC_STOP)
    else $error("standby pin ignored");
  AST_BUS_HIGH:
    assert property (OSC_STOP && !HW_STANDBY && CTRL_OE ##1 OSC_STOP && !HW_STANDBY
      |-> CHIP_SELECT_N == 8'hFF)
    else $error("selects not high in standby");
  AST_ADDR_HOLD:
    assert property (OSC_STOP && ADDR_OE && !HW_STANDBY ##1 OSC_STOP && !HW_STANDBY
      |-> $stable(ADDR_OUT))
    else $error("address moved in standby");
  AST_MOD_RST: assert property (((MOD_STOP | $past(MOD_STOP)) & ~MOD_RESET) == 6'h00)
    else $error("module reset dropped early");
endmodule : pdm_top_chk

bind pdm_top pdm_top_chk chk_u (
  .CLK(CLK), .RST_N(RST_N), .CHIP_INIT_PIN_N(CHIP_INIT_PIN_N),
  .HW_STANDBY_PIN_N(HW_STANDBY_PIN_N), .HALT_EXEC(HALT_EXEC), .NMI_REQ(NMI_REQ),
  .IRQ_ACCEPT(IRQ_ACCEPT), .CPU_HALT(CPU_HALT), .INTR_EXCEPTION(INTR_EXCEPTION),
  .HW_STANDBY(HW_STANDBY), .OSC_STOP(OSC_STOP), .ADDR_OUT(ADDR_OUT), .ADDR_OE(ADDR_OE),
  .CHIP_SELECT_N(CHIP_SELECT_N), .CTRL_OE(CTRL_OE), .MOD_STOP(MOD_STOP),
  .MOD_RESET(MOD_RESET)
);

/* pdm_top_tb.sv */
module pdm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] SYS = pdm_pkg::SYS_PWR_CTRL_OFS;
  localparam logic [19:0] HI = pdm_pkg::MOD_HW_STANDBY_PIN_N_HI_OFS;
  localparam logic [19:0] LO = pdm_pkg::MOD_HW_STANDBY_PIN_N_LO_OFS;
  localparam logic [7:0] WV [4] = '{8'h00, 8'hFF, 8'h04, 8'h83};
  localparam logic [7:0] MB [6] = '{8'h01, 8'h02, 8'h10, 8'h08, 8'h04, 8'h01};
  // only the short wait codes fit the run length
  localparam logic [2:0] WC [4] = '{3'h6, 3'h0, 3'h1, 3'h2};
  logic clk, rst_n, reg_wr, reg_rd, init_n, hws_n, halt, nmi, per_irq, acc, sclk;
  logic [19:0] reg_addr;
  logic [7:0] reg_wdata, cpu_cs_n, rdata, cs_n;
  logic [2:0] irq, irq_en;
  logic [3:0] cpu_stb_n;
  wire logic [3:0] stb_n;
  logic [23:0] cpu_addr, addr_out;
  logic cpu_halt, intr, dev_rst, hw_hw_standby_pin_n, osc_stop, addr_oe, ctrl_oe, clk_oe, clk_out, ce;
  logic [5:0] mod_stop, mod_rst;
  int mismatches = 0;
  int cmp_count = 0;

  pdm_top dut_u (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .CHIP_INIT_PIN_N(init_n),
    .HW_STANDBY_PIN_N(hws_n), .HALT_EXEC(halt), .NMI_REQ(nmi), .EXT_IRQ_REQ(irq),
    .EXT_IRQ_EN(irq_en), .PERIPH_IRQ_REQ(per_irq), .IRQ_ACCEPT(acc), .CPU_ADDR(cpu_addr),
    .CPU_CS_N(cpu_cs_n), .CPU_STROBE_N(cpu_stb_n), .SYS_CLK_IN(sclk), .CPU_HALT(cpu_halt),
    .INTR_EXCEPTION(intr), .DEVICE_RESET(dev_rst), .HW_STANDBY(hw_hw_standby_pin_n), .OSC_STOP(osc_stop),
    .ADDR_OUT(addr_out), .ADDR_OE(addr_oe), .CHIP_SELECT_N(cs_n), .ADDRESS_STROBE_N(stb_n[3]),
    .READ_STROBE_N(stb_n[2]), .HIGH_WRITE_STROBE_N(stb_n[1]), .LOW_WRITE_STROBE_N(stb_n[0]),
    .CTRL_OE(ctrl_oe), .SYS_CLK_OUT(clk_out), .SYS_CLK_OE(clk_oe), .MOD_STOP(mod_stop),
    .MOD_RESET(mod_rst)
  );

  // ----------------------------------------
  // clock and access tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) sclk <= ~sclk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask : rd

  task automatic sleep_in;
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    #1;
  endtask : sleep_in

  // order: nmi, peripheral, accept, ext requests, ext enables
  task automatic drv(input logic [8:0] v);
    @(posedge clk);
    {nmi, per_irq, acc, irq, irq_en} <= v;
  endtask : drv

  task automatic init_pulse;
    @(posedge clk);
    init_n <= 1'b0;
    cyc(2);
    chk("dev_rst", dev_rst, 1'b1);
    chk("halt", cpu_halt, 1'b0);
    @(posedge clk);
    init_n <= 1'b1;
  endtask : init_pulse

  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    #300000;
    mismatches++;
    close_out();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    int n;
    {rst_n, reg_wr, reg_rd, halt, nmi, per_irq, acc, sclk, irq, irq_en} = '0;
    {reg_addr, reg_wdata, init_n, hws_n} = {28'h0000000, 2'h3};
    {cpu_addr, cpu_cs_n, cpu_stb_n} = {24'h5A5A5A, 8'hA5, 4'h5};
    ce = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(SYS, 8'h09);
    rd(HI, 8'h78);
    rd(LO, 8'h00);
    rd(20'h00000, 8'h00);
    // a write under a low clock enable is lost
    @(posedge clk);
    ce <= 1'b0;
    wr(LO, 8'hFF);
    ce <= 1'b1;
    rd(LO, 8'h00);
    foreach (WV[i]) begin
      wr(HI, WV[i]);
      rd(HI, WV[i] | 8'h78);
      wr(LO, WV[i]);
      rd(LO, WV[i]);
    end
    chk("clk_oe", clk_oe, 1'b0);
    chk("clk_out", clk_out, 1'b0);
    wr(HI, 8'h00);
    wr(LO, 8'hE2);
    cyc(2);
    chk("clk_oe", clk_oe, 1'b1);
    chk("clk_out", clk_out, !sclk);
    chk("mod_stop", mod_stop, 6'h00);
    for (int i = 0; i < 6; i++) begin
      wr(i < 2 ? HI : LO, MB[i]);
      cyc(2);
      chk("mod_stop", mod_stop, 32'h1 << i);
      wr(i < 2 ? HI : LO, 8'h00);
      cyc(1);
      chk("mod_rst", mod_rst, 32'h1 << i);
      cyc(2);
      chk("mod_rst", mod_rst, 6'h00);
    end
    // wake sources: nmi alone, enabled ext with accept, peripheral with accept
    for (int i = 0; i < 3; i++) begin
      wr(LO, 8'h10);
      sleep_in();
      chk("osc", osc_stop, 1'b0);
      chk("mod_stop", mod_stop, 6'h04);
      drv(9'h03F);
      cyc(5);
      chk("halt", cpu_halt, 1'b1);
      drv({i == 0, i == 2, i > 0, i == 1 ? 3'h7 : 3'h0, 3'h7});
      cyc(1);
      chk("halt", cpu_halt, 1'b0);
      chk("intr", intr, 1'b1);
      cyc(1);
      chk("intr", intr, 1'b0);
      drv(9'h000);
    end
    wr(LO, 8'h55);
    sleep_in();
    init_pulse();
    rd(LO, 8'h00);
    wr(HI, 8'h07);
    sleep_in();
    @(posedge clk);
    hws_n <= 1'b0;
    cyc(2);
    chk("hw", {hw_hw_standby_pin_n, osc_stop, mod_stop}, 8'hFF);
    @(posedge clk);
    hws_n <= 1'b1;
    init_pulse();
    rd(HI, 8'h78);
    foreach (WC[i]) begin
      wr(SYS, {1'b1, WC[i], 4'h9});
      sleep_in();
      cyc(1);
      chk("osc", osc_stop, 1'b1);
      chk("oe", {addr_oe, ctrl_oe}, 2'h0);
      drv(9'h0C8);
      cyc(4);
      chk("osc", osc_stop, 1'b1);
      drv(9'h052);
      drv(9'h000);
      #1;
      n = 0;
      while (cpu_halt === 1'b1 && n < 300000) begin
        cyc(1);
        n++;
      end
      chk("settle", n, WC[i] == 3'h6 ? 1024 : 8192 << WC[i]);
      chk("intr", intr, 1'b1);
      rd(SYS, {1'b1, WC[i], 4'h9});
      wr(SYS, 8'h09);
    end
    // 32768 states is 131 us here, above the external clock floor;
    // the bench clock is not a crystal, so the 7 ms floor does not bind
    wr(SYS, 8'hAB);
    sleep_in();
    cyc(2);
    chk("bus", {addr_oe, ctrl_oe, cs_n, stb_n}, 14'h3FFF);
    rd(pdm_pkg::PWR_STATUS_OFS, 8'h02);
    @(posedge clk);
    cpu_addr <= 24'h123456;
    cyc(3);
    chk("addr", addr_out, 24'h5A5A5A);
    init_pulse();
    close_out();
  end
endmodule : pdm_top_tb
